// >>> bench/serial_peer.sv
/*
 * partner model: remote asynchronous transceiver on the serial pins.
 * assumes the bench sets bitClk to the core's bit period in clk cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
    input wire logic clk,
    input wire logic line,
    output logic rxd
);
    int bitClk = 32; // bit period in clk cycles
    initial begin
        rxd = 1'h1; // line rests high
    end
    // ****************************************
    // helpers
    // ****************************************
    // wait n edges, then step off the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // ****************************************
    // frame out of the peer
    // ****************************************
    // start low, lsb first, optional parity, stops; faults on request
    task automatic sendFrame(input logic [8:0] d, input int len, input logic [1:0] par,
        input int stops, input logic badPar, input logic badStop);
        logic p;
        p = par[0] ^ badPar;
        rxd = 1'h0; // start bit
        step(bitClk);
        for (int i = 0; i < len; i++) begin
            rxd = d[i]; // lsb first
            p = p ^ d[i];
            step(bitClk);
        end
        if (par[1]) begin
            rxd = p; // parity after msb
            step(bitClk);
        end
        rxd = ~badStop; // stop bits
        step(bitClk * stops);
        rxd = 1'h1; // back to idle
        step(1); // one idle cycle keeps frames apart on the pin
    endtask
    // ****************************************
    // frame into the peer
    // ****************************************
    // find the falling edge, then sample each bit in its middle
    task automatic getFrame(input int len, input logic parEn, output logic [8:0] d,
        output logic p, output logic s, output int gap);
        d = 9'h000;
        p = 1'h0;
        gap = 0;
        while (line !== 1'h0 && gap < 20000) begin
            step(1);
            gap++;
        end
        step(bitClk / 2);
        for (int i = 0; i < len; i++) begin
            step(bitClk);
            d[i] = line;
        end
        if (parEn) begin
            step(bitClk);
            p = line;
        end
        step(bitClk);
        s = line;
    endtask
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
/*
 * testbench for the serial transceiver core: frames both ways against the
 * peer model, error and overrun cases, serial clock pin checks.
 * assumes the core and the peer model are compiled before this file.
 */
`timescale 1ns/1ps
`default_nettype none
`include "usart_params.svh"
module tb_top;
    // ****************************************
    // signals
    // ****************************************
    logic clk, rstn, dbl, master, cpol, stopSel, txe, rxe, txValid, txClr, rxReady;
    logic [1:0] mode, parSel, pc;
    logic [2:0] lenSel;
    logic [11:0] div, sdiv;
    logic [8:0] txData, rxData, w, d1, d2;
    logic txEmpty, txDone, rxFe, rxPe, rxOvr, rxValid, rxdPin, txdPin, sckOut, sckOe;
    logic p1, s1, s2, sck;
    int fails, checks, g, n, len;
    logic [2:0] lenCode [5] = '{3'h0, 3'h1, 3'h2, 3'h3, `LEN_NINE_CODE};
    logic [1:0] parCode [3] = '{2'h0, 2'h2, 2'h3};
    usart_frame_and_clock_core DUT (.clk(clk), .rstn(rstn), .serialModeSelect(mode),
        .doubleSpeedSelect(dbl), .master(master), .cpol(cpol), .dataLengthSelect(lenSel),
        .paritySelect(parSel), .stopBitsSelect(stopSel), .bitRateDivisor(div),
        .syncBitRateDivisor(sdiv), .txe(txe), .rxe(rxe), .txData(txData),
        .txValid(txValid), .txBufferEmptyFlag(txEmpty), .txCompleteFlag(txDone),
        .txCompleteClear(txClr), .rxData(rxData), .rxFrameError(rxFe),
        .rxParityError(rxPe), .rxOverrun(rxOvr), .rxValid(rxValid), .rxReady(rxReady),
        .rxdPin(rxdPin), .txdPin(txdPin), .sckIn(sck), .sckOut(sckOut), .sckOe(sckOe));
    serial_peer peer (.clk(clk), .line(txdPin), .rxd(rxdPin));
    // ****************************************
    // tasks
    // ****************************************
    // wait n edges, then step off the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // compare and count
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // verdict and end of run
    task automatic stop_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // frame settings shared by both directions
    task automatic cfg(input logic [1:0] m, input logic db, input logic [2:0] lc,
        input logic [1:0] pr, input logic st, input logic [11:0] dv);
        mode = m;
        dbl = db;
        lenSel = lc;
        parSel = pr;
        stopSel = st;
        div = dv;
    endtask
    // hold the word until an edge sees the buffer empty
    task automatic writeWord(input logic [8:0] v);
        int k;
        k = 0;
        step(1);
        txData = v;
        txValid = 1'h1;
        while (txEmpty !== 1'h1 && k < 5000) begin
            step(1);
            k++;
        end
        step(1);
        txValid = 1'h0;
    endtask
    // wait for a head word, compare it with its flags, pop it
    task automatic readWord(input logic [8:0] v, input logic fe, input logic pe);
        int k;
        k = 0;
        step(1);
        while (rxValid !== 1'h1 && k < 2000) begin
            step(1);
            k++;
        end
        check(rxData, v);
        check(9'(rxFe), 9'(fe));
        check(9'(rxPe), 9'(pe));
        rxReady = 1'h1;
        step(1);
        rxReady = 1'h0;
    endtask
    // cycles up to the next rising edge of the master clock
    task automatic waitRise(output int k);
        logic prev;
        prev = sckOut;
        k = 0;
        while (!(prev === 1'h0 && sckOut === 1'h1) && k < 500) begin
            prev = sckOut;
            step(1);
            k++;
        end
    endtask
    // ****************************************
    // clock and watchdog
    // ****************************************
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        stop_test;
    end
    // ****************************************
    // tests
    // ****************************************
    initial begin
        rstn = 1'h0;
        {dbl, master, cpol, stopSel, txValid, txClr, rxReady, sck} = 8'h00;
        {txe, rxe} = 2'h3;
        {mode, parSel, lenSel} = 7'h03;
        {div, sdiv, txData} = 33'h000000000;
        fails = 0;
        checks = 0;
        repeat (8) @(posedge clk);
        #1;
        rstn = 1'h1;
        check(9'(txdPin), 9'(`LINE_IDLE));
        check(9'(txEmpty), 9'h1);
        check(9'(txDone), 9'h0);
        check(9'(sckOe), 9'h0);
        $display("test reset done");
        // two words back to back while a frame arrives
        cfg(`MODE_ASYNC, 1'h0, 3'h3, 2'h0, 1'h0, 12'h001);
        peer.bitClk = 32;
        fork
            begin
                writeWord(9'h0A5);
                writeWord(9'h03C);
                check(9'(txEmpty), 9'h0);
            end
            begin
                peer.getFrame(8, 1'h0, d1, p1, s1, g);
                peer.getFrame(8, 1'h0, d2, p1, s2, g);
            end
            peer.sendFrame(9'h05A, 8, 2'h0, 1, 1'h0, 1'h0);
        join
        check(d1, 9'h0A5);
        check(d2, 9'h03C);
        check(9'(g <= 18), 9'h1);
        check(9'(s2), 9'h1);
        check(9'(txDone), 9'h0);
        step(40);
        check(9'(txDone), 9'h1);
        check(9'(txEmpty), 9'h1);
        txClr = 1'h1;
        step(1);
        txClr = 1'h0;
        check(9'(txDone), 9'h0);
        readWord(9'h05A, 1'h0, 1'h0);
        $display("test back to back done");
        // every length, parity kind, both speeds, both stop counts
        for (int i = 0; i < 5; i++) begin
            len = i < 4 ? 5 + i : 9;
            pc = parCode[i % 3];
            w = (9'h1B6 ^ 9'(i * 37)) & ((9'h001 << len) - 9'h001);
            cfg(`MODE_ASYNC, i[0], lenCode[i], pc, i[1], 12'h001);
            peer.bitClk = i[0] ? 16 : 32;
            fork
                writeWord(w);
                peer.getFrame(len, pc[1], d1, p1, s1, g);
                peer.sendFrame(w, len, pc, 1 + i[1], 1'h0, 1'h0);
            join
            check(d1, w);
            if (pc[1]) begin
                check(9'(p1), 9'(^w ^ pc[0]));
            end
            check(9'(s1), 9'h1);
            readWord(w, 1'h0, 1'h0);
            step(64);
        end
        $display("test formats done");
        // parity fault, stop fault, overrun, flush
        cfg(`MODE_ASYNC, 1'h0, 3'h3, 2'h2, 1'h0, 12'h001);
        peer.bitClk = 32;
        peer.sendFrame(9'h033, 8, 2'h2, 1, 1'h1, 1'h0);
        readWord(9'h033, 1'h0, 1'h1);
        peer.sendFrame(9'h044, 8, 2'h2, 1, 1'h0, 1'h1);
        readWord(9'h044, 1'h1, 1'h0);
        peer.sendFrame(9'h011, 8, 2'h2, 1, 1'h0, 1'h0);
        peer.sendFrame(9'h022, 8, 2'h2, 1, 1'h0, 1'h0);
        peer.sendFrame(9'h077, 8, 2'h2, 1, 1'h0, 1'h0);
        step(4);
        check(9'(rxOvr), 9'h1);
        readWord(9'h011, 1'h0, 1'h0);
        check(9'(rxOvr), 9'h0);
        readWord(9'h022, 1'h0, 1'h0);
        check(9'(rxValid), 9'h0);
        peer.sendFrame(9'h055, 8, 2'h2, 1, 1'h0, 1'h0);
        check(9'(rxValid), 9'h1);
        rxe = 1'h0;
        step(1);
        check(9'(rxValid), 9'h0);
        rxe = 1'h1;
        $display("test receive faults done");
        // clock pin per mode, master rate and idle level
        master = 1'h1;
        for (int m = 0; m < 3; m++) begin
            mode = m == 2 ? `MODE_SPI : 2'(m);
            step(2);
            check(9'(sckOe), 9'(m != 0));
        end
        mode = `MODE_SYNC;
        master = 1'h0;
        step(2);
        check(9'(sckOe), 9'h0);
        master = 1'h1;
        cpol = 1'h1;
        sdiv = 12'h002;
        writeWord(9'h0C3);
        waitRise(n);
        waitRise(n);
        check(9'(n), 9'h006);
        n = 0;
        while (txDone !== 1'h1 && n < 2000) begin
            step(1);
            n++;
        end
        check(9'(txDone), 9'h1);
        step(8);
        check(9'(sckOut), 9'h1);
        // slave: far end clocks at 1MHz, bench samples on its falling edge
        master = 1'h0;
        cpol = 1'h0;
        writeWord(9'h0A7);
        step(2);
        check(9'(txdPin), 9'h0);
        for (int i = 0; i < 11; i++) begin
            sck = 1'h1;
            step(50);
            if (i < 9) begin
                w = {txdPin, w[8:1]};
            end else if (i == 9) begin
                check(9'(txdPin), 9'h1);
            end
            sck = 1'h0;
            step(50);
        end
        check(w, 9'h1A7);
        check(9'(txDone), 9'h1);
        $display("test serial clock done");
        stop_test;
    end
endmodule
`default_nettype wire

// >>> rtl/usart_frame_and_clock_core.sv
/*
 * serial transceiver core: bit-rate generator, master/slave serial clock,
 * transmitter with one holding word, receiver with a two-entry buffer.
 * assumes control ports come from registers on clk; pins are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "usart_params.svh"
module usart_frame_and_clock_core #(
    parameter int DIVW = 12
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [1:0] serialModeSelect,
    input wire logic doubleSpeedSelect,
    input wire logic master,
    input wire logic cpol,
    input wire logic [2:0] dataLengthSelect,
    input wire logic [1:0] paritySelect,
    input wire logic stopBitsSelect,
    input wire logic [DIVW-1:0] bitRateDivisor,
    input wire logic [DIVW-1:0] syncBitRateDivisor,
    input wire logic txe,
    input wire logic rxe,
    input wire logic [8:0] txData,
    input wire logic txValid,
    output logic txBufferEmptyFlag,
    output logic txCompleteFlag,
    input wire logic txCompleteClear,
    output logic [8:0] rxData,
    output logic rxFrameError,
    output logic rxParityError,
    output logic rxOverrun,
    output logic rxValid,
    input wire logic rxReady,
    input wire logic rxdPin,
    output logic txdPin,
    input wire logic sckIn,
    output logic sckOut,
    output logic sckOe
);
    import usart_pkg::*;

    // ****************************************
    // frame settings, shared by both paths
    // ****************************************
    logic syncMode, spiMode, parEn, parOdd;
    logic [3:0] len;
    logic [8:0] mask;
    logic [4:0] osLast;
    always_comb begin
        syncMode = serialModeSelect != `MODE_ASYNC;
        spiMode = serialModeSelect == `MODE_SPI;
        parEn = paritySelect[`PAR_EN_BIT];
        parOdd = paritySelect[`PAR_ODD_BIT];
        // nine-bit code, else five plus the low two code bits
        len = (dataLengthSelect == `LEN_NINE_CODE) ? `LEN_NINE
            : `LEN_BASE + {2'h0, dataLengthSelect[1:0]};
        mask = 9'h1FF >> (`LEN_NINE - len);
        // oversampling span
        osLast = (doubleSpeedSelect ? `OS_DOUBLE : `OS_NORMAL) - 5'h01;
    end

    // ****************************************
    // bit-rate generator and serial clock
    // ****************************************
    logic [DIVW-1:0] divCnt, next_divCnt;
    logic s1, s2, s3, r1, r2, rPrev; // synchronisers
    logic next_sckOut, next_sckOe, tick, running;
    logic rise, fall, changeEdge, sampleEdge;
    tx_state_t txState, next_txState;
    // divider and edge selection
    always_comb begin
        tick = divCnt == '0;
        // reload gives period divisor+1
        next_divCnt = tick ? (syncMode ? syncBitRateDivisor : bitRateDivisor)
                           : divCnt - 1'b1;
        // master clock runs through a frame and back to idle level
        running = syncMode && master && (txState != TX_IDLE || sckOut != cpol);
        next_sckOut = sckOut;
        if (!running) begin
            next_sckOut = cpol;
        end else if (tick) begin
            next_sckOut = !sckOut;
        end
        next_sckOe = syncMode && master;
        if (master) begin
            rise = running && tick && !sckOut;
            fall = running && tick && sckOut;
        end else begin
            rise = syncMode && s2 && !s3;
            fall = syncMode && !s2 && s3;
        end
        changeEdge = cpol ? fall : rise;
        sampleEdge = cpol ? rise : fall;
    end
    // clock registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            divCnt <= '0;
            {s1, s2, s3} <= 3'h0;
            {r1, r2, rPrev} <= 3'h7;
            sckOut <= 1'b0;
            sckOe <= 1'b0;
        end else begin
            divCnt <= next_divCnt;
            {s1, s2, s3} <= {sckIn, s1, s2};
            {r1, r2, rPrev} <= {rxdPin, r1, r2};
            sckOut <= next_sckOut;
            sckOe <= next_sckOe;
        end
    end

    // ****************************************
    // transmitter
    // ****************************************
    logic [8:0] hold, next_hold, txShift, next_txShift;
    logic holdFull, next_holdFull, next_txd, next_txEmpty, next_txDone;
    logic [3:0] txCnt, next_txCnt;
    logic [4:0] txOs, next_txOs;
    logic accept, load, txAdv, frameEnd;
    // transmit sequence and holding word
    always_comb begin
        accept = txValid && txBufferEmptyFlag;
        txAdv = syncMode ? changeEdge : (tick && txOs == osLast);
        frameEnd = txAdv && (spiMode ? (txState == TX_DATA && txCnt == len - 4'h1)
            : (txState == TX_STOP && txCnt[0] == stopBitsSelect));
        load = holdFull && txe && (txState == TX_IDLE || frameEnd);
        next_txState = txState;
        next_txShift = txShift;
        next_txCnt = txCnt;
        next_txOs = (tick && !syncMode) ? ((txOs == osLast) ? 5'h00 : txOs + 5'h01) : txOs;
        if (load) begin
            next_txShift = hold;
            next_txCnt = 4'h0;
            next_txOs = 5'h00;
            next_txState = spiMode ? TX_DATA : TX_START;
        end else if (frameEnd) begin
            next_txState = TX_IDLE;
        end else if (txAdv) begin
            case (txState)
                TX_START: begin
                    next_txState = TX_DATA;
                end
                TX_DATA: begin
                    next_txCnt = txCnt + 4'h1;
                    if (txCnt == len - 4'h1) begin
                        next_txCnt = 4'h0;
                        next_txState = parEn ? TX_PAR : TX_STOP;
                    end
                end
                TX_PAR: begin
                    next_txState = TX_STOP;
                end
                TX_STOP: begin
                    next_txCnt = 4'h1; // second stop
                end
                default: begin
                    next_txState = TX_IDLE;
                end
            endcase
        end
        // line level from the coming state
        case (next_txState)
            TX_START: next_txd = 1'b0;
            TX_DATA: next_txd = next_txShift[next_txCnt];
            TX_PAR: next_txd = ^(next_txShift & mask) ^ parOdd;
            default: next_txd = `LINE_IDLE;
        endcase
        next_holdFull = (holdFull && !load) || accept;
        next_hold = accept ? txData : hold;
        next_txEmpty = !next_holdFull;
        // set wins over clear
        next_txDone = (frameEnd && !holdFull && !accept)
            || (txCompleteFlag && !txCompleteClear && !accept);
    end
    // transmit registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txState <= TX_IDLE;
            hold <= `RST_DATA;
            txShift <= `RST_DATA;
            holdFull <= 1'b0;
            txCnt <= 4'h0;
            txOs <= 5'h00;
            txdPin <= `LINE_IDLE;
            txBufferEmptyFlag <= 1'b1;
            txCompleteFlag <= 1'b0;
        end else begin
            txState <= next_txState;
            hold <= next_hold;
            txShift <= next_txShift;
            holdFull <= next_holdFull;
            txCnt <= next_txCnt;
            txOs <= next_txOs;
            txdPin <= next_txd;
            txBufferEmptyFlag <= next_txEmpty;
            txCompleteFlag <= next_txDone;
        end
    end

    // ****************************************
    // receiver
    // ****************************************
    rx_state_t rxState, next_rxState;
    logic [8:0] rxShift, next_rxShift;
    logic [3:0] rxCnt, next_rxCnt;
    logic [4:0] rxOs, next_rxOs;
    logic rxPar, next_rxPar, rxSample, push;
    logic [10:0] pushWord;
    // receive sequence
    always_comb begin
        rxSample = syncMode ? sampleEdge : (tick && rxOs == osLast);
        next_rxState = rxState;
        next_rxShift = rxShift;
        next_rxCnt = rxCnt;
        next_rxPar = rxPar;
        next_rxOs = (tick && !syncMode) ? rxOs + 5'h01 : rxOs;
        push = 1'b0;
        pushWord = {parEn && (rxPar != (^(rxShift & mask) ^ parOdd)), !r2, rxShift & mask};
        case (rxState)
            RX_IDLE: begin
                next_rxOs = 5'h00;
                next_rxCnt = 4'h0;
                if (!syncMode && rPrev && !r2) begin
                    next_rxState = RX_START;
                end else if (spiMode && sampleEdge) begin
                    next_rxShift[0] = r2;
                    next_rxCnt = 4'h1;
                    next_rxState = RX_DATA;
                end else if (syncMode && sampleEdge && !r2) begin
                    next_rxState = RX_DATA;
                end
            end
            RX_START: begin
                // mid start bit
                if (tick && rxOs == (osLast >> 1)) begin
                    next_rxOs = 5'h00;
                    next_rxState = r2 ? RX_IDLE : RX_DATA;
                end
            end
            default: begin
                if (rxSample) begin
                    next_rxOs = 5'h00;
                    case (rxState)
                        RX_DATA: begin
                            next_rxShift[rxCnt] = r2;
                            next_rxCnt = rxCnt + 4'h1;
                            if (rxCnt == len - 4'h1) begin
                                next_rxState = parEn ? RX_PAR : RX_STOP;
                                if (spiMode) begin
                                    next_rxState = RX_STOP;
                                end
                            end
                        end
                        RX_PAR: begin
                            next_rxPar = r2;
                            next_rxState = RX_STOP;
                        end
                        default: begin
                            // first stop closes the frame
                            push = 1'b1;
                            next_rxState = RX_IDLE;
                        end
                    endcase
                end
                if (spiMode && rxState == RX_STOP) begin
                    push = 1'b1;
                    pushWord[9] = 1'b0;
                    next_rxState = RX_IDLE;
                end
            end
        endcase
        if (!rxe) begin
            push = 1'b0;
            next_rxState = RX_IDLE;
        end
    end
    // receive registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxState <= RX_IDLE;
            rxShift <= `RST_DATA;
            rxCnt <= 4'h0;
            rxOs <= 5'h00;
            rxPar <= 1'b0;
        end else begin
            rxState <= next_rxState;
            rxShift <= next_rxShift;
            rxCnt <= next_rxCnt;
            rxOs <= next_rxOs;
            rxPar <= next_rxPar;
        end
    end

    // ****************************************
    // two-entry receive buffer
    // ****************************************
    logic [10:0] slot1, next_slot1, next_head;
    logic v1, next_v1, next_v0, pop, next_ovr;
    // head stage drives the outputs directly
    always_comb begin
        pop = rxValid && rxReady;
        next_head = {rxParityError, rxFrameError, rxData};
        next_slot1 = slot1;
        next_v0 = rxValid;
        next_v1 = v1;
        if (pop) begin
            next_head = slot1;
            next_v0 = v1;
            next_v1 = 1'b0;
        end
        if (push && !next_v0) begin
            next_head = pushWord;
            next_v0 = 1'b1;
        end else if (push && !next_v1) begin
            next_slot1 = pushWord;
            next_v1 = 1'b1;
        end
        // the clearing read wins over overrun set
        next_ovr = (push && rxValid && v1 && !pop) || (rxOverrun && !pop);
        if (!rxe) begin
            next_v0 = 1'b0;
            next_v1 = 1'b0;
            next_ovr = 1'b0;
        end
    end
    // buffer registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {rxParityError, rxFrameError, rxData} <= 11'h000;
            slot1 <= 11'h000;
            rxValid <= 1'b0;
            v1 <= 1'b0;
            rxOverrun <= 1'b0;
        end else begin
            {rxParityError, rxFrameError, rxData} <= next_head;
            slot1 <= next_slot1;
            rxValid <= next_v0;
            v1 <= next_v1;
            rxOverrun <= next_ovr;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    async_pin_a: assert property ((!syncMode) [*2] |-> !sckOe)
        else $error("clock pin enabled in async mode");
    master_pin_a: assert property (master && syncMode |=> sckOe)
        else $error("master clock pin not driven");
    idle_high_a: assert property (txState == TX_IDLE |-> txdPin)
        else $error("line low while idle");
    start_low_a: assert property (txState == TX_START |-> !txdPin)
        else $error("start bit not low");
    tx_parity_a: assert property (txState == TX_PAR |->
        txdPin == (^(txShift & mask) ^ parOdd))
        else $error("wrong parity bit");
    empty_flag_a: assert property (accept |=> !txBufferEmptyFlag)
        else $error("empty flag set with word waiting");
    tx_done_a: assert property ($rose(txCompleteFlag) |-> txState == TX_IDLE)
        else $error("complete flag during frame");
    rx_flush_a: assert property (!rxe |=> !rxValid && !rxOverrun)
        else $error("buffer kept while disabled");
    overrun_a: assert property (push && rxValid && v1 && !pop && rxe |=> rxOverrun)
        else $error("overrun not flagged");
    cover_txframe_c: cover property (txState == TX_STOP ##1 txState == TX_START);
    cover_rxpush_c: cover property (push && !rxValid);
    cover_overrun_c: cover property ($rose(rxOverrun));
    cover_master_c: cover property (running && $rose(sckOut));
endmodule
`default_nettype wire

// >>> rtl/usart_params.svh
/*
 * constants of the serial transceiver core: field codes, oversampling
 * figures and reset values.
 * assumes it is included by name from the core file.
 */
`ifndef USART_PARAMS_SVH
`define USART_PARAMS_SVH

// ****************************************
// mode field codes
// ****************************************
`define MODE_ASYNC 2'h0
`define MODE_SYNC 2'h1
`define MODE_SPI 2'h3

// ****************************************
// frame field codes
// ****************************************
`define LEN_NINE_CODE 3'h7
`define LEN_BASE 4'h5
`define LEN_NINE 4'h9
`define PAR_EN_BIT 1
`define PAR_ODD_BIT 0

// ****************************************
// oversampling per bit
// ****************************************
`define OS_NORMAL 5'h10
`define OS_DOUBLE 5'h08

// ****************************************
// reset values
// ****************************************
`define LINE_IDLE 1'h1
`define RST_DATA 9'h000

`endif

// >>> rtl/usart_pkg.sv
/*
 * types shared by the serial transceiver core.
 * assumes nothing of its surroundings.
 */
package usart_pkg;
    // transmit sequence
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
    // receive sequence
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
endpackage
